/* File: common/thermal_throttle_trigger_consts.vh */
`ifndef THERMAL_THROTTLE_TRIGGER_CONSTS_VH
`define THERMAL_THROTTLE_TRIGGER_CONSTS_VH
`define TTT_LIMITS_ADDR 12'h1a2
`define TTT_TJ_LSB 16
`define TTT_TJ_MSB 23
`define TTT_OFS_LSB 24
`define TTT_OFS_MSB 29
`define TTT_OFS_RESET 6'h00
`define TTT_TJ_DEFAULT 8'h64
`define TTT_SENSORS 4
`define TTT_MOD_PERIOD_US 32
`define TTT_CLK_MHZ 125
// modulation period in clocks: 32 us at 125 MHz
`define TTT_MOD_CYCLES 16'h0fa0
`define TTT_STEP_CYCLES 16'h0100
`define TTT_RATIO_MIN 8'h00
`define TTT_RATIO_MAX 8'hff
`define TTT_HYST_CYCLES 16'h0400
`endif

/* File: src/thermal_throttle_trigger.v */
// Functional notes
// [RL1] throttle activates when any sensor reading meets or exceeds the limit
// [RL2] limit is junction maximum, or junction maximum less activation offset
// [RL3] while active, lower core and graphics frequency and voltage adaptively
// [RL4] stay active while hot; keep reducing until the circuit deactivates
// [RL5] reduce power by ratio/voltage steps and by core clock duty gating
// [RL6] junction maximum is read-only at 0x1a2 bits 23:16
// [RL7] offset written in bits 29:24 is subtracted to form trip point
// [RL8] offset resets to zero so trip equals junction maximum
// [RL9] junction maximum field never changes when an offset applies
// [RL10] protection is always enabled; no disable control exists
// [RL11] throttling acts autonomously without software or interrupts
// [RL12] software should set trip below other trips such as passive cooling
`include "thermal_throttle_trigger_consts.vh"
`default_nettype none
module thermal_throttle_trigger #(
  parameter [7:0] TJ_MAX = `TTT_TJ_DEFAULT,
  parameter [15:0] MOD_CYCLES = `TTT_MOD_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [4*8-1:0] die_temp_sensor,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [63:0] reg_wdata,
  output reg [63:0] reg_rdata,
  output reg reg_ack,
  output reg throttle_circuit,
  output reg [7:0] ratio_limit,
  output reg [7:0] volt_limit,
  output reg [7:0] gfx_ratio_limit,
  output reg core_clk_en
);
  // ************************************************************
  // limit register
  // ************************************************************
  reg [5:0] ofs_q;
  // the single register decodes on its full address
  function is_limits;
    input [11:0] addr;
    begin
      is_limits = addr == `TTT_LIMITS_ADDR;
    end
  endfunction
  // junction field is a constant, so writes can never reach it [RL6] [RL9]
  function [63:0] limits_word;
    input [7:0] tj;
    input [5:0] ofs;
    begin
      limits_word = {34'h0, ofs, tj, 16'h0};
    end
  endfunction
  wire hit = is_limits(reg_addr);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_q <= `TTT_OFS_RESET; // [RL8]
    end else if (reg_wr && hit) begin
      ofs_q <= reg_wdata[`TTT_OFS_MSB:`TTT_OFS_LSB]; // [RL7]
    end
  end
  // every access is answered, even at a free address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_wr | reg_rd;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 64'h0;
    end else if (reg_rd) begin
      reg_rdata <= hit ? limits_word(TJ_MAX, ofs_q) : 64'h0; // [RL6]
    end
  end
  // ************************************************************
  // trip compare
  // ************************************************************
  // offset larger than the junction maximum clamps trip to zero
  function [7:0] trip_of;
    input [7:0] tj;
    input [5:0] ofs;
    reg [8:0] diff;
    begin
      diff = {1'b0, tj} - {3'h0, ofs};
      trip_of = diff[8] ? 8'h00 : diff[7:0];
    end
  endfunction
  // one sensor reading against the trip point
  function reached;
    input [7:0] temp;
    input [7:0] trip_pt;
    begin
      reached = temp >= trip_pt;
    end
  endfunction
  wire [7:0] trip = trip_of(TJ_MAX, ofs_q); // [RL2] [RL7]
  reg hot;
  integer i;
  always @* begin
    hot = 1'b0;
    for (i = 0; i < `TTT_SENSORS; i = i + 1) begin
      if (reached(die_temp_sensor[i*8 +: 8], trip)) begin
        hot = 1'b1; // [RL1]
      end
    end
  end
  // ************************************************************
  // timers
  // ************************************************************
  // wrapping count shared by the step and modulation timers
  function [15:0] wrap_inc;
    input [15:0] cnt;
    input [15:0] period;
    begin
      if (cnt == period - 16'h1) begin
        wrap_inc = 16'h0;
      end else begin
        wrap_inc = cnt + 16'h1;
      end
    end
  endfunction
  reg [15:0] step_q;
  reg [15:0] step_d;
  reg [15:0] hyst_q;
  reg [15:0] hyst_d;
  reg [15:0] mod_q;
  reg [15:0] mod_d;
  // step timer runs free, so a new event waits at most one step
  wire step_tick = step_q == 16'h0;
  always @* begin
    step_d = wrap_inc(step_q, `TTT_STEP_CYCLES);
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 16'h0;
    end else begin
      step_q <= step_d;
    end
  end
  // ************************************************************
  // activation and hysteresis
  // ************************************************************
  // no enable input on purpose: protection cannot be turned off [RL10]
  reg throttle_d;
  always @* begin
    throttle_d = throttle_circuit;
    hyst_d = hyst_q;
    if (hot) begin
      throttle_d = 1'b1; // [RL1] [RL11]
      hyst_d = `TTT_HYST_CYCLES;
    end else if (hyst_q != 16'h0) begin
      hyst_d = hyst_q - 16'h1; // [RL4]
    end else begin
      throttle_d = 1'b0;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      throttle_circuit <= 1'b0;
      hyst_q <= 16'h0;
    end else begin
      throttle_circuit <= throttle_d;
      hyst_q <= hyst_d;
    end
  end
  // ************************************************************
  // frequency and voltage limits
  // ************************************************************
  // one step toward the floor or the ceiling, saturating at either end
  function [7:0] limit_step;
    input [7:0] cur;
    input down;
    begin
      if (down) begin
        limit_step = (cur == `TTT_RATIO_MIN) ? cur : cur - 8'h1;
      end else begin
        limit_step = (cur == `TTT_RATIO_MAX) ? cur : cur + 8'h1;
      end
    end
  endfunction
  reg [7:0] ratio_d;
  reg [7:0] volt_d;
  reg [7:0] gfx_d;
  always @* begin
    ratio_d = ratio_limit;
    volt_d = volt_limit;
    gfx_d = gfx_ratio_limit;
    if (step_tick) begin
      ratio_d = limit_step(ratio_limit, throttle_circuit); // [RL3] [RL5]
      volt_d = limit_step(volt_limit, throttle_circuit); // [RL3] [RL4]
      gfx_d = limit_step(gfx_ratio_limit, throttle_circuit); // [RL3]
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_limit <= `TTT_RATIO_MAX;
      volt_limit <= `TTT_RATIO_MAX;
      gfx_ratio_limit <= `TTT_RATIO_MAX;
    end else begin
      ratio_limit <= ratio_d;
      volt_limit <= volt_d;
      gfx_ratio_limit <= gfx_d;
    end
  end
  // ************************************************************
  // clock modulation
  // ************************************************************
  // duty gating only once ratio steps are exhausted, 25 percent on
  wire at_min = ratio_limit == `TTT_RATIO_MIN;
  reg clk_en_d;
  always @* begin
    if (throttle_circuit && at_min) begin
      mod_d = wrap_inc(mod_q, MOD_CYCLES);
      clk_en_d = mod_q < (MOD_CYCLES >> 2); // [RL5]
    end else begin
      mod_d = 16'h0;
      clk_en_d = 1'b1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_q <= 16'h0;
      core_clk_en <= 1'b1;
    end else begin
      mod_q <= mod_d;
      core_clk_en <= clk_en_d;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/sensor_model.sv */
`default_nettype none
module sensor_model(input wire logic [7:0] t,input wire logic [1:0] s,
  output logic [31:0] die_temp_sensor);
  timeunit 1ns/1ps;
  // idle sensors read cool so only the chosen one can trip
  always_comb begin
    die_temp_sensor=32'h20202020;
    die_temp_sensor[s*8+:8]=t;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_thermal_throttle_trigger.sv */
`default_nettype none
module tb_thermal_throttle_trigger;
  timeunit 1ns/1ps;
  logic clk=0,rst_n=0,reg_wr=0,reg_rd=0,throttle_circuit,reg_ack,core_clk_en;
  logic [1:0] s=0;
  logic [7:0] t=0,ratio_limit,volt_limit,gfx_ratio_limit;
  logic [11:0] reg_addr=0;
  logic [63:0] reg_wdata=0,reg_rdata;
  wire [31:0] die_temp_sensor;
  int miscompares=0,total_checks=0;
  sensor_model pm(.t(t),.s(s),.die_temp_sensor(die_temp_sensor));
  thermal_throttle_trigger #(.MOD_CYCLES(16'h0010)) dut(.*);
  task chk(input [63:0] v,e);
    total_checks++;
    if (v!==e) begin
      miscompares++;
      $display("wrong value %0t got %h",$time,v);
    end
  endtask
  task acc(input w,input [11:0] a,input [63:0] d);
    reg_wr=w; reg_rd=!w; reg_addr=a; reg_wdata=d;
    @(posedge clk); #1 reg_wr=0; reg_rd=0;
    chk(reg_ack,1);
    @(posedge clk); #1 chk(reg_ack,0);
  endtask
  task regs;
    acc(0,12'h1a2,0); chk(reg_rdata,64'h640000);
    acc(1,12'h1a2,'1); acc(0,12'h1a2,0); chk(reg_rdata,64'h3f640000);
    acc(0,12'h1a3,0); chk(reg_rdata,0);
    acc(1,12'h1a2,64'h5000000);
  endtask
  task heat;
    int n;
    s=2; t=8'h5e; repeat(3) @(posedge clk); #1 chk(throttle_circuit,0);
    t=8'h5f; repeat(2) @(posedge clk); #1 chk(throttle_circuit,1);
    repeat(66000) @(posedge clk); #1 chk(ratio_limit,0);
    chk(gfx_ratio_limit,0);
    chk(volt_limit,0);
    n=0;
    repeat(16) begin @(posedge clk); #1 n+=!core_clk_en; end
    chk(n,12);
    t=8'h20; repeat(1000) @(posedge clk); #1 chk(throttle_circuit,1);
    repeat(100) @(posedge clk); #1 chk(throttle_circuit,0);
    chk(core_clk_en,1);
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d",total_checks,miscompares);
    if (miscompares==0&&total_checks>0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #4 clk=~clk;
  initial begin
    repeat(10) @(posedge clk); #1 rst_n=1;
    regs; heat; give_verdict;
  end
  initial begin
    #700us miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire

/* File: testbench/ttt_chk_assertions.sv */
`default_nettype none
module ttt_chk(input wire clk,rst_n,reg_rd,reg_ack,throttle_circuit,
  core_clk_en,input wire [31:0] die_temp_sensor,input wire [11:0] reg_addr,
  input wire [63:0] reg_rdata,input wire [7:0] ratio_limit,volt_limit,
  gfx_ratio_limit);
  timeunit 1ns/1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // any reading at the junction maximum trips, whatever the offset
  wire hot=die_temp_sensor[7:0]>=8'h64||die_temp_sensor[15:8]>=8'h64||
    die_temp_sensor[23:16]>=8'h64||die_temp_sensor[31:24]>=8'h64;
  trip_on_a: assert property (hot |=> throttle_circuit)
    else $error("no trip");
  stay_on_a: assert property ($fell(throttle_circuit) |-> !$past(hot))
    else $error("early release");
  ratio_dn_a: assert property (throttle_circuit |=>
    ratio_limit<=$past(ratio_limit)) else $error("ratio rose");
  gfx_dn_a: assert property (throttle_circuit |=>
    gfx_ratio_limit<=$past(gfx_ratio_limit)) else $error("gfx rose");
  volt_dn_a: assert property (throttle_circuit |=>
    volt_limit<=$past(volt_limit)) else $error("volt rose");
  ratio_up_a: assert property (!throttle_circuit |=>
    ratio_limit>=$past(ratio_limit)) else $error("ratio fell");
  clk_run_a: assert property (!throttle_circuit |=> core_clk_en)
    else $error("gated");
  tj_ro_a: assert property (reg_rd&&reg_addr==12'h1a2 |=>
    reg_rdata[23:16]==8'h64) else $error("tj");
  cover property (throttle_circuit);
  cover property (!core_clk_en);
  cover property ($fell(throttle_circuit));
endmodule
bind thermal_throttle_trigger ttt_chk chk(.*);
`default_nettype wire
